// ---- hw/flash_iap_pkg.sv ----
// Package: register map, field layout and codes of the flash write/erase sequencer.
// Assumes one 40 MHz clock domain and a 32-bit AXI4-Lite register bus.
package flash_iap_pkg;
   // Register indexes; byte address is four times the index
   localparam logic [7:0] IDX_UNLOCK  = 8'hF1;
   localparam logic [7:0] IDX_ADDR_LO = 8'hF2;
   localparam logic [7:0] IDX_ADDR_HI = 8'hF3;
   localparam logic [7:0] IDX_REGION  = 8'hF4;
   localparam logic [7:0] IDX_WDATA   = 8'hF5;
   localparam logic [7:0] IDX_CTRL    = 8'hF6;
   localparam logic [7:0] IDX_STATUS  = 8'hF7;
   localparam logic [7:0] IDX_CONFIG  = 8'hF8;
   // Control register fields
   localparam int         BIT_BOOT_SEL = 7;
   localparam int         BIT_ERASE    = 5;
   localparam int         BIT_PROGRAM  = 4;
   localparam logic [1:0] CMD_START    = 2'h2;
   // Status and config fields
   localparam int BIT_BUSY     = 2;
   localparam int BIT_OPEN     = 1;
   localparam int BIT_REFUSED  = 0;
   localparam int BIT_MAINLOCK = 2;
   // Region codes
   localparam logic [7:0] REGION_MAIN = 8'h00;
   localparam logic [7:0] REGION_UID  = 8'h01;
   localparam logic [7:0] REGION_EEP  = 8'h02;
   localparam logic [7:0] REGION_BOOT = 8'h03;
   // Boot area sizes: first main-area address owned by the boot area
   localparam logic [14:0] BOOT_START_NONE = 15'h4000;
   localparam logic [14:0] BOOT_START_1K   = 15'h3C00;
   localparam logic [14:0] BOOT_START_2K   = 15'h3800;
   localparam logic [14:0] BOOT_START_4K   = 15'h3000;
   // Reset values
   localparam logic [7:0] RST_BYTE   = 8'h00;
   localparam logic [1:0] RST_BOOTSZ = 2'h0;
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_BUSY = 2'b10
   } op_state_t;
endpackage : flash_iap_pkg

// ---- hw/unlock_timer.sv ----
// Unlock window: a non-zero load opens it for that many clocks.
// Assumes load and consume come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module unlock_timer
   import flash_iap_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         i_clk,     // System clock
   input  wire logic         i_reset,   // Async reset, high
   input  wire logic         i_load,    // Unlock value written
   input  wire logic [W-1:0] i_value,   // Window length n
   input  wire logic         i_consume, // Start command seen
   output logic              o_open,    // Window open
   output logic [W-1:0]      o_left     // Clocks remaining
);
   logic [W-1:0] left;

   // Count down; a command or expiry closes the window
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         left <= '0;
      end else if (i_load) begin
         left <= i_value;
      end else if (i_consume) begin
         left <= '0;
      end else if (left != '0) begin
         left <= left - 1'b1;
      end
   end

   assign o_open = (left != '0);
   assign o_left = left;
endmodule : unlock_timer
`default_nettype wire

// ---- hw/op_permit.sv ----
// Checks whether an armed operation may touch the flash.
// Assumes all inputs are register values on the same clock.
`timescale 1ns/1ps
`default_nettype none
module op_permit
   import flash_iap_pkg::*;
(
   input  wire logic [7:0]  i_region,    // Region code
   input  wire logic [13:0] i_addr,      // Target address
   input  wire logic [1:0]  i_boot_size, // Boot area size
   input  wire logic        i_main_lock, // Main area locked
   input  wire logic        i_erase,     // Erase armed
   input  wire logic        i_program,   // Program armed
   output logic             o_ok         // Operation allowed
);
   logic [14:0] boot_start;

   // Lowest main-area address that belongs to the boot area
   always_comb begin
      unique case (i_boot_size)
         2'h0:    boot_start = BOOT_START_NONE;
         2'h1:    boot_start = BOOT_START_1K;
         2'h2:    boot_start = BOOT_START_2K;
         default: boot_start = BOOT_START_4K;
      endcase
   end

   // Exactly one arm bit; only main (unlocked, below boot) or EEPROM
   always_comb begin
      o_ok = 1'b0;
      if (i_erase ^ i_program) begin
         if (i_region == REGION_EEP) begin
            o_ok = 1'b1;
         end else if (i_region == REGION_MAIN) begin
            o_ok = !i_main_lock && ({1'b0, i_addr} < boot_start);
         end
      end
   end
endmodule : op_permit
`default_nettype wire

// ---- hw/flash_iap_ctrl.sv ----
// Flash in-application write/erase sequencer with AXI4-Lite registers.
// Assumes the flash array answers each start pulse with one done pulse.
//
// Notes on behaviour
// R1: Control bit 7 picks the restart area after software reset: main or boot.
// R2: Erase arm set, then command 10 erases the addressed sector.
// R3: Program arm set, then command 10 writes the data byte to the address.
// R4: Only command code 10 starts anything; other codes start nothing.
// R5: Software sets an arm bit first, then writes command 10 to launch; here the arm bit must be in the same control write as command 10.
// R6: Software never sets both arm bits; one operation at a time.
// R7: Software follows a launch with at least eight no-operation instructions.
// R8: Region 0 main area, 1 unique-ID read only, 2 EEPROM read/write.
// R9: Region 3 allows boot-area code reads only from boot code; never writes.
// R10: Non-zero unlock n opens flash operations for n clocks.
// R11: Software writes region, data, address, then unlock value, in that order.
// R12: CPU is held during an operation and resumes when it completes.
// R13: With main area locked, writes in region 0 are ignored.
// R14: Software masks interrupts for non-zero regions, restores region 0 after.
// R15: Boot area size is none, 1K, 2K or 4K, set by boot size setting.
// R16: Target address is split: low register bits 7..0, high register 6 bits.
// R17: The boot area is never programmed or erased.
// R18: A command outside an open unlock window is ignored.
// R19: Reset clears both arm bits and the command field.
`timescale 1ns/1ps
`default_nettype none
module flash_iap_ctrl
   import flash_iap_pkg::*;
#(
   parameter int AW = 12
) (
   input  wire logic          i_clk,            // 40 MHz system clock
   input  wire logic          i_reset,          // Async reset, high
   input  wire logic [AW-1:0] i_awaddr,         // Write address
   input  wire logic          i_awvalid,        // Write address valid
   output logic               o_awready,        // Write address ready
   input  wire logic [31:0]   i_wdata,          // Write data
   input  wire logic [3:0]    i_wstrb,          // Write strobes
   input  wire logic          i_wvalid,         // Write data valid
   output logic               o_wready,         // Write data ready
   output logic [1:0]         o_bresp,          // Write response
   output logic               o_bvalid,         // Write response valid
   input  wire logic          i_bready,         // Write response ready
   input  wire logic [AW-1:0] i_araddr,         // Read address
   input  wire logic          i_arvalid,        // Read address valid
   output logic               o_arready,        // Read address ready
   output logic [31:0]        o_rdata,          // Read data
   output logic [1:0]         o_rresp,          // Read response
   output logic               o_rvalid,         // Read data valid
   input  wire logic          i_rready,         // Read data ready
   input  wire logic          i_run_from_boot,  // CPU runs boot code
   input  wire logic          i_flash_done,     // Flash operation finished
   output logic               o_flash_erase,    // Sector erase start pulse
   output logic               o_flash_program,  // Byte program start pulse
   output logic [13:0]        o_flash_addr,     // Target address
   output logic [7:0]         o_flash_wdata,    // Byte to program
   output logic [7:0]         o_flash_region,   // Region for reads and ops
   output logic               o_boot_read_en,   // Boot area code reads allowed
   output logic               o_cpu_hold,       // Stall program counter
   output logic               o_boot_restart    // Restart from boot area
);
   op_state_t   state;
   logic        aw_got;
   logic        w_got;
   logic [7:0]  w_idx;
   logic [31:0] w_data;
   logic        w_lane0;
   logic [7:0]  region_select;
   logic [7:0]  write_data;
   logic [13:0] target_address;
   logic        boot_area_select;
   logic        erase_arm;
   logic        program_arm;
   logic [1:0]  cmd;
   logic [1:0]  boot_size_setting;
   logic        main_lock;
   logic        refused;
   logic        window_open;
   logic [7:0]  window_left;
   logic        permit_ok;
   logic        do_write;
   logic        wr_hit;
   logic        cmd_write;
   logic        launch_req;
   logic        launch;
   logic [7:0]  r_idx;
   logic        r_hit;
   logic [7:0]  r_byte;

   // Write happens once address and data are both captured
   assign do_write   = aw_got && w_got && !o_bvalid;
   assign wr_hit     = (w_idx >= IDX_UNLOCK) && (w_idx <= IDX_CONFIG);
   assign cmd_write  = do_write && w_lane0 && (w_idx == IDX_CTRL);
   assign launch_req = cmd_write && (w_data[1:0] == CMD_START);           // [R4]
   assign launch     = launch_req && window_open && permit_ok             // [R18]
                       && (state == ST_IDLE);
   assign r_idx      = i_araddr[9:2];
   assign r_hit      = (r_idx >= IDX_UNLOCK) && (r_idx <= IDX_CONFIG)
                       && (i_araddr[AW-1:10] == '0);

   // Window timer: any start attempt closes it
   unlock_timer #(.W(8)) u_timer (
      .i_clk     (i_clk),
      .i_reset   (i_reset),
      .i_load    (do_write && w_lane0 && (w_idx == IDX_UNLOCK)),          // [R10]
      .i_value   (w_data[7:0]),
      .i_consume (launch_req),
      .o_open    (window_open),
      .o_left    (window_left)
   );

   // Permission check on the arm bits being written with the command
   op_permit u_permit (
      .i_region    (region_select),
      .i_addr      (target_address),
      .i_boot_size (boot_size_setting),
      .i_main_lock (main_lock),
      .i_erase     (w_data[BIT_ERASE]),
      .i_program   (w_data[BIT_PROGRAM]),
      .o_ok        (permit_ok)                                           // [R13] [R17]
   );

   // AXI write address and data capture, in either order
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_awready <= 1'b1;
         o_wready  <= 1'b1;
         aw_got    <= 1'b0;
         w_got     <= 1'b0;
         w_idx     <= RST_BYTE;
         w_data    <= '0;
         w_lane0   <= 1'b0;
         o_bvalid  <= 1'b0;
         o_bresp   <= RESP_OKAY;
      end else begin
         if (i_awvalid && o_awready) begin
            o_awready <= 1'b0;
            aw_got    <= 1'b1;
            w_idx     <= (i_awaddr[AW-1:10] == '0) ? i_awaddr[9:2] : RST_BYTE;
         end
         if (i_wvalid && o_wready) begin
            o_wready <= 1'b0;
            w_got    <= 1'b1;
            w_data   <= i_wdata;
            w_lane0  <= i_wstrb[0];
         end
         if (do_write) begin
            aw_got   <= 1'b0;
            w_got    <= 1'b0;
            o_bvalid <= 1'b1;
            o_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (o_bvalid && i_bready) begin
            o_bvalid  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
         end
      end
   end

   // Setup registers: region, data, split address, config
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         region_select     <= RST_BYTE;
         write_data        <= RST_BYTE;
         target_address    <= '0;
         boot_size_setting <= RST_BOOTSZ;
         main_lock         <= 1'b0;
      end else if (do_write && w_lane0) begin
         unique case (w_idx)
            IDX_REGION:  region_select       <= w_data[7:0];               // [R8]
            IDX_WDATA:   write_data          <= w_data[7:0];
            IDX_ADDR_LO: target_address[7:0] <= w_data[7:0];               // [R16]
            IDX_ADDR_HI: target_address[13:8] <= w_data[5:0];              // [R16]
            IDX_CONFIG: begin
               boot_size_setting <= w_data[1:0];                           // [R15]
               main_lock         <= w_data[BIT_MAINLOCK];
            end
            default: ;
         endcase
      end
   end

   // Control register; command field clears when the operation ends
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         boot_area_select <= 1'b0;
         erase_arm        <= 1'b0;                                         // [R19]
         program_arm      <= 1'b0;                                         // [R19]
         cmd              <= 2'h0;                                         // [R19]
      end else if (cmd_write) begin
         boot_area_select <= w_data[BIT_BOOT_SEL];                         // [R1]
         erase_arm        <= w_data[BIT_ERASE];
         program_arm      <= w_data[BIT_PROGRAM];
         cmd              <= launch ? CMD_START : 2'h0;
      end else if ((state == ST_BUSY) && i_flash_done) begin
         cmd <= 2'h0;
      end
   end

   // Sticky refusal flag; a new refusal beats a software clear
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         refused <= 1'b0;
      end else if (launch_req && !launch) begin
         refused <= 1'b1;                                                  // [R18]
      end else if (do_write && w_lane0 && (w_idx == IDX_STATUS) && w_data[BIT_REFUSED]) begin
         refused <= 1'b0;
      end
   end

   // Sequencer: launch pulses the flash, CPU stalls until done
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state           <= ST_IDLE;
         o_flash_erase   <= 1'b0;
         o_flash_program <= 1'b0;
         o_cpu_hold      <= 1'b0;
         o_flash_addr    <= '0;
         o_flash_wdata   <= RST_BYTE;
      end else begin
         o_flash_erase   <= 1'b0;
         o_flash_program <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (launch) begin
                  state           <= ST_BUSY;
                  o_flash_erase   <= w_data[BIT_ERASE];                    // [R2]
                  o_flash_program <= w_data[BIT_PROGRAM];                  // [R3]
                  o_flash_addr    <= target_address;
                  o_flash_wdata   <= write_data;                           // [R3]
                  o_cpu_hold      <= 1'b1;                                 // [R12]
               end
            end
            ST_BUSY: begin
               if (i_flash_done) begin
                  state      <= ST_IDLE;
                  o_cpu_hold <= 1'b0;                                      // [R12]
               end
            end
         endcase
      end
   end

   // Region and boot-read outputs, plus restart selection
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_flash_region <= REGION_MAIN;
         o_boot_read_en <= 1'b0;
         o_boot_restart <= 1'b0;
      end else begin
         o_flash_region <= region_select;                                  // [R8]
         o_boot_read_en <= (region_select == REGION_BOOT) && i_run_from_boot; // [R9]
         o_boot_restart <= boot_area_select;                               // [R1]
      end
   end

   // Read mux
   always_comb begin
      unique case (r_idx)
         IDX_UNLOCK:  r_byte = window_left;
         IDX_ADDR_LO: r_byte = target_address[7:0];
         IDX_ADDR_HI: r_byte = {2'h0, target_address[13:8]};
         IDX_REGION:  r_byte = region_select;
         IDX_WDATA:   r_byte = write_data;
         IDX_CTRL:    r_byte = {boot_area_select, 1'b0, erase_arm, program_arm, 2'h0, cmd};
         IDX_STATUS:  r_byte = {5'h0, (state == ST_BUSY), window_open, refused};
         IDX_CONFIG:  r_byte = {5'h0, main_lock, boot_size_setting};
         default:     r_byte = 8'h00;
      endcase
   end

   // AXI read channel: one beat, answer the cycle after the address
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= '0;
         o_rresp   <= RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rdata   <= r_hit ? {24'h0, r_byte} : 32'h0;
         o_rresp   <= r_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
      end
   end

   // Checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   a_erase_launch: assert property (launch && w_data[BIT_ERASE] |=>         // [R2]
      o_flash_erase && !o_flash_program && o_flash_addr == $past(target_address))
      else $error("erase launch did not pulse erase");
   a_program_launch: assert property (launch && w_data[BIT_PROGRAM] |=>     // [R3]
      o_flash_program && o_flash_wdata == $past(write_data))
      else $error("program launch did not pulse program");
   a_bad_code_idle: assert property (cmd_write && w_data[1:0] != CMD_START  // [R4]
      |=> !o_flash_erase && !o_flash_program)
      else $error("reserved command started an operation");
   a_closed_window: assert property (launch_req && !window_open             // [R18]
      |=> !o_flash_erase && !o_flash_program ##1 refused)
      else $error("command taken with window closed");
   a_key_opens: assert property (do_write && w_lane0 && w_idx == IDX_UNLOCK // [R10]
      && w_data[7:0] != 8'h00 |=> window_open && window_left == $past(w_data[7:0]))
      else $error("unlock write did not open window");
   a_key_expires: assert property (window_open && window_left == 8'h01      // [R10]
      && !(do_write && w_idx == IDX_UNLOCK) |=> !window_open)
      else $error("window outlived its count");
   a_hold_busy: assert property ((state == ST_BUSY) && !i_flash_done        // [R12]
      |=> o_cpu_hold)
      else $error("cpu not held during operation");
   a_hold_release: assert property (state == ST_BUSY && i_flash_done        // [R12]
      |=> !o_cpu_hold ##1 !o_cpu_hold)
      else $error("cpu not released after done");
   a_boot_untouched: assert property ((o_flash_erase || o_flash_program)    // [R17]
      |-> o_flash_region != REGION_BOOT && o_flash_region != REGION_UID)
      else $error("operation on boot or id area");
   a_main_locked: assert property (launch_req && main_lock                  // [R13]
      && region_select == REGION_MAIN |=> !o_flash_erase && !o_flash_program)
      else $error("locked main area accepted an operation");
   a_boot_read: assert property (region_select == REGION_BOOT               // [R9]
      && i_run_from_boot |=> o_boot_read_en)
      else $error("boot read not enabled");
   a_region_follow: assert property (region_select != o_flash_region        // [R8]
      |=> o_flash_region == $past(region_select))
      else $error("region output did not follow register");
   a_restart_follow: assert property (boot_area_select != o_boot_restart    // [R1]
      |=> o_boot_restart == $past(boot_area_select))
      else $error("restart area did not follow control bit");
   a_window_shut: assert property (launch_req                              // [R10]
      |=> !window_open)
      else $error("start command left the window open");
   a_two_arms: assert property (cmd_write && w_data[BIT_ERASE]              // [R6]
      && w_data[BIT_PROGRAM] |=> !o_flash_erase && !o_flash_program)
      else $error("both arm bits started an operation");
   a_boot_addr: assert property (launch && region_select == REGION_MAIN     // [R17]
      && boot_size_setting == 2'h3 |-> target_address < BOOT_START_4K[13:0])
      else $error("operation launched inside the boot area");
endmodule : flash_iap_ctrl
`default_nettype wire

// ---- sim/flash_array_model.sv ----
// Flash array stand-in: answers each start pulse with one done pulse.
// Assumes start pulses are one clock wide and never overlap a busy array.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
   input  wire logic       i_clk,   // System clock
   input  wire logic       i_reset, // Async reset, high
   input  wire logic       i_start, // Erase or program pulse
   input  wire logic [3:0] i_lat,   // Extra busy clocks, prompt or slow
   output logic            o_done   // One-cycle done pulse
);
   int left;
   // Count busy clocks after a start, then pulse done once
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         left   <= 0;
         o_done <= 1'b0;
      end else begin
         o_done <= (left == 1);
         if (i_start) begin
            left <= i_lat + 2;
         end else if (left > 0) begin
            left <= left - 1;
         end
      end
   end
endmodule : flash_array_model
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench: AXI4-Lite master tasks, flash model, queue of expected starts.
// Assumes the flash sequencer package and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import flash_iap_pkg::*;
   logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, boot_run, done;
   logic        awready, wready, bvalid, arready, rvalid, f_er, f_pg, rd_en, hold, restart;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rs, rv;
   logic [3:0]  wstrb, lat;
   logic [1:0]  bresp, rresp, rr, br;
   logic [13:0] f_addr;
   logic [7:0]  f_data, f_region;
   int          err_total, cmp_count, cyc;
   logic [24:0] q[$];

   flash_iap_ctrl dut (.i_clk(clk), .i_reset(rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_run_from_boot(boot_run), .i_flash_done(done), .o_flash_erase(f_er), .o_flash_program(f_pg),
      .o_flash_addr(f_addr), .o_flash_wdata(f_data), .o_flash_region(f_region),
      .o_boot_read_en(rd_en), .o_cpu_hold(hold), .o_boot_restart(restart));
   flash_array_model flash (.i_clk(clk), .i_reset(rst), .i_start(f_er | f_pg), .i_lat(lat), .o_done(done));

   // Clock at 25 ns period
   always #12.5 clk = ~clk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task print_verdict;
      $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : print_verdict

   // Start monitor: each start pulse must match the oldest expected operation
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         print_verdict;
      end
      if (f_er === 1'b1 || f_pg === 1'b1) begin
         chk({f_er, f_pg, f_addr, f_data, hold}, q.size() ? q.pop_front() : 32'hFFFFFFFF);
      end
   end

   // Register write: address and data offered together, response awaited
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic got;
      got     = 1'b0;
      awaddr  <= {2'b00, idx, 2'b00};
      wdata   <= {24'h0, d};
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!got) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            got = 1'b1;
            br  = bresp;
         end
      end
   endtask : wr

   // Register read: data and response taken at the rvalid edge
   task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic got;
      got     = 1'b0;
      araddr  <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!got) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            got = 1'b1;
            d   = rdata;
            r   = rresp;
         end
      end
   endtask : rd

   // Full preparation and launch; st is the expected status afterwards
   task automatic op(input logic [7:0] rg, input logic [13:0] a, input logic [7:0] ctl, input int gap,
                     input logic [7:0] st);
      int n;
      rs = xs(rs);
      lat <= rs[11:8];
      wr(IDX_REGION, rg);
      wr(IDX_WDATA, rs[7:0]);
      wr(IDX_ADDR_LO, a[7:0]);
      wr(IDX_ADDR_HI, {2'b00, a[13:8]});
      wr(IDX_UNLOCK, (gap > 0) ? 8'h03 : 8'hF0);
      repeat (gap) @(posedge clk);
      if (st == 0) q.push_back({ctl[5], ctl[4], a, rs[7:0], 1'b1});
      wr(IDX_CTRL, ctl);
      repeat (8) @(posedge clk);
      for (n = 0; n < 40 && hold !== 1'b0; n++) @(posedge clk);
      chk(hold, 1'b0);
      chk(q.size(), 0);
      rd(IDX_STATUS, rv, rr);
      chk(rv, st);
      wr(IDX_STATUS, 8'h01);
   endtask : op

   // Main sequence
   initial begin
      clk = 0; rst = 1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; boot_run = 0; lat = 0;
      err_total = 0; cmp_count = 0; cyc = 0; rs = 32'd51792;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(IDX_CTRL, rv, rr);
      chk(rv, 32'h0);
      rd(8'h10, rv, rr);
      chk(rr, RESP_SLVERR);
      wr(8'h10, 8'h5A);
      chk(br, RESP_SLVERR);
      op(REGION_EEP, 14'h2A5C, 8'h12, 0, 8'h00);
      op(REGION_MAIN, 14'h0100, 8'h22, 0, 8'h00);
      op(REGION_EEP, 14'h0100, 8'h32, 0, 8'h01);
      for (int c = 0; c < 4; c++) if (c != 2) op(REGION_EEP, 14'h0010, 8'h10 | 8'(c), 0, 8'h02);
      for (int r = 1; r < 5; r++) if (r != 2) op(8'(r), 14'h0010, 8'h12, 0, 8'h01);
      wr(IDX_CONFIG, 8'h04);
      op(REGION_MAIN, 14'h0010, 8'h12, 0, 8'h01);
      op(REGION_EEP, 14'h0010, 8'h12, 0, 8'h00);
      for (int s = 1; s < 4; s++) begin
         wr(IDX_CONFIG, 8'(s));
         op(REGION_MAIN, 14'(14'h0 - (14'h400 << (s - 1))), 8'h22, 0, 8'h01);
         op(REGION_MAIN, 14'(14'h3FFF - (14'h400 << (s - 1))), 8'h12, 0, 8'h00);
      end
      wr(IDX_CONFIG, 8'h00);
      op(REGION_EEP, 14'h0020, 8'h12, 8, 8'h01);
      wr(IDX_CTRL, 8'h80);
      chk(br, RESP_OKAY);
      @(negedge clk);
      chk(restart, 1'b1);
      @(posedge clk);
      wr(IDX_CTRL, 8'h00);
      @(negedge clk);
      chk(restart, 1'b0);
      @(posedge clk);
      boot_run <= 1'b1;
      wr(IDX_REGION, REGION_BOOT);
      @(negedge clk);
      chk({rd_en, f_region}, {1'b1, REGION_BOOT});
      @(posedge clk);
      boot_run <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(rd_en, 1'b0);
      @(posedge clk);
      wr(IDX_REGION, REGION_MAIN);
      repeat (6) begin
         rs = xs(rs);
         op(REGION_EEP, rs[29:16], 8'h12, 0, 8'h00);
      end
      print_verdict;
   end
endmodule : testbench
`default_nettype wire
